/* core/cef_flags.sv */
// Purpose: Upper interrupt flags of a CAN controller with mailbox status.
// Assumes: Counters and receive events are synchronous to sys_clk.
// Notes: Register port answers reads one cycle later.
`timescale 1ns/1ps
`include "cef_map.svh"

module cef_flags (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Register port.
    input wire cef_pkg::cef_addr_t addr,
    input wire cef_pkg::cef_word_t wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output cef_pkg::cef_word_t rd_data,
    // Protocol engine status.
    input wire cef_pkg::cef_cnt_t transmit_error_counter,
    input wire cef_pkg::cef_cnt_t receive_error_counter,
    input wire logic overload_tx,
    input wire logic rx_done,
    input wire logic rx_remote,
    input wire cef_pkg::cef_mbox_t rx_mbox,
    // Interrupt.
    output logic irq
);
    import cef_pkg::*;

    // Write-one-to-clear with set winning over clear.
    function automatic cef_word_t w1c(cef_word_t cur, cef_word_t set,
                                      cef_word_t clr);
        w1c = set | (cur & ~clr);
    endfunction

    cef_word_t flags_ff;
    cef_word_t rxc_ff;
    cef_word_t rfr_ff;
    cef_word_t mbim_ff;
    cef_word_t istat_ff;
    cef_word_t imask_ff;
    cef_word_t rd_data_ff;
    logic irq_ff;

    cef_word_t nxt_flags;
    cef_word_t nxt_rxc;
    cef_word_t nxt_rfr;
    cef_word_t nxt_mbim;
    cef_word_t nxt_istat;
    cef_word_t nxt_imask;
    cef_word_t nxt_rd_data;
    logic nxt_irq;

    // Address decode.
    wire wr_flags = wr_en && (addr == `CEF_ADDR_FLAGS);
    wire wr_rxc = wr_en && (addr == `CEF_ADDR_RXC);
    wire wr_rfr = wr_en && (addr == `CEF_ADDR_RFR);
    wire wr_mbim = wr_en && (addr == `CEF_ADDR_MBIM);
    wire wr_imask = wr_en && (addr == `CEF_ADDR_IMASK);
    wire rd_istat = rd_en && (addr == `CEF_ADDR_ISTAT);

    // Error state thresholds.
    wire bus_off = (transmit_error_counter >= `CEF_BUS_OFF_LIMIT);
    wire passive = (transmit_error_counter >= `CEF_PASSIVE_LIMIT)
        || (receive_error_counter >= `CEF_PASSIVE_LIMIT);
    wire rx_warn = (receive_error_counter >= `CEF_WARN_LIMIT);
    wire tx_warn = (transmit_error_counter >= `CEF_WARN_LIMIT);

    // Mailbox reception.
    wire cef_word_t mb_hot = 16'h0001 << rx_mbox;
    wire cef_word_t rxc_set = rx_done ? mb_hot : 16'h0000;
    wire cef_word_t rfr_set = (rx_done && rx_remote) ? mb_hot
        : 16'h0000;
    wire rx_unmasked = rx_done && !mbim_ff[rx_mbox];
    wire rfr_sum_set = rx_unmasked && rx_remote;
    wire rxm_sum_set = rx_unmasked;

    assign nxt_rxc = w1c(rxc_ff, rxc_set,
        wr_rxc ? wr_data : 16'h0000);
    assign nxt_rfr = w1c(rfr_ff, rfr_set,
        wr_rfr ? wr_data : 16'h0000);
    assign nxt_mbim = wr_mbim ? wr_data : mbim_ff;
    assign nxt_imask = wr_imask ? (wr_data & `CEF_FLAG_MASK) : imask_ff;

    // Hardware set terms of the flag register.
    wire cef_word_t flag_set = {
        overload_tx && !bus_off,
        bus_off,
        passive,
        rx_warn,
        tx_warn,
        11'h000};

    // Only bits 15 to 11 accept write-one clears.
    wire cef_word_t flag_clr = wr_flags ? (wr_data & `CEF_W1C_MASK)
        : 16'h0000;
    wire cef_word_t w1c_part = w1c(flags_ff, flag_set, flag_clr)
        & `CEF_W1C_MASK;

    // Summary flags stay up while their status registers hold a bit.
    wire rfr_sum = rfr_sum_set
        || (flags_ff[`CEF_BIT_RFR_SUM] && (nxt_rfr != 16'h0000));
    wire rxm_sum = rxm_sum_set
        || (flags_ff[`CEF_BIT_RXM_SUM] && (nxt_rxc != 16'h0000));

    assign nxt_flags = w1c_part | {5'h00, rfr_sum, rxm_sum, 9'h000};

    // Each rising flag latches a sticky event; a read clears it.
    wire cef_word_t flag_rise = nxt_flags & ~flags_ff;
    assign nxt_istat = w1c(istat_ff, flag_rise,
        rd_istat ? istat_ff : 16'h0000);
    assign nxt_irq = ((nxt_istat & nxt_imask) != 16'h0000);

    // Read multiplexer; unmapped addresses read zero.
    wire cef_word_t rd_mux =
        (addr == `CEF_ADDR_FLAGS) ? flags_ff :
        (addr == `CEF_ADDR_RXC) ? rxc_ff :
        (addr == `CEF_ADDR_RFR) ? rfr_ff :
        (addr == `CEF_ADDR_MBIM) ? mbim_ff :
        (addr == `CEF_ADDR_ISTAT) ? istat_ff :
        (addr == `CEF_ADDR_IMASK) ? imask_ff :
        (addr == `CEF_ADDR_TEC) ? {7'h00, transmit_error_counter} :
        (addr == `CEF_ADDR_REC) ? {7'h00, receive_error_counter} : 16'h0000;
    assign nxt_rd_data = rd_en ? rd_mux : 16'h0000;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            flags_ff <= `CEF_WORD_RESET;
            rxc_ff <= `CEF_WORD_RESET;
            rfr_ff <= `CEF_WORD_RESET;
            mbim_ff <= `CEF_MBIM_RESET;
            istat_ff <= `CEF_WORD_RESET;
            imask_ff <= `CEF_WORD_RESET;
        end else begin
            flags_ff <= nxt_flags;
            rxc_ff <= nxt_rxc;
            rfr_ff <= nxt_rfr;
            mbim_ff <= nxt_mbim;
            istat_ff <= nxt_istat;
            imask_ff <= nxt_imask;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rd_data_ff <= `CEF_WORD_RESET;
            irq_ff <= 1'b0;
        end else begin
            rd_data_ff <= nxt_rd_data;
            irq_ff <= nxt_irq;
        end
    end

    assign rd_data = rd_data_ff;
    assign irq = irq_ff;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_overload_set:
    assert property (overload_tx && !bus_off
        |=> flags_ff[`CEF_BIT_OVERLOAD])
        else $error("Overload flag not set.");

    a_overload_block:
    assert property (overload_tx && bus_off
        && !flags_ff[`CEF_BIT_OVERLOAD] |=> !flags_ff[`CEF_BIT_OVERLOAD])
        else $error("Overload flag set while bus off.");

    a_bus_off_set:
    assert property (transmit_error_counter >= 9'h100 |=> flags_ff[`CEF_BIT_BUS_OFF])
        else $error("Bus-off flag not set.");

    a_passive_set:
    assert property ((transmit_error_counter >= 9'h080 || receive_error_counter >= 9'h080)
        |=> flags_ff[`CEF_BIT_PASSIVE])
        else $error("Error-passive flag not set.");

    a_rx_warn_set:
    assert property (receive_error_counter >= 9'h060 |=> flags_ff[`CEF_BIT_RX_WARN])
        else $error("Receive warning flag not set.");

    a_tx_warn_set:
    assert property (transmit_error_counter >= 9'h060 |=> flags_ff[`CEF_BIT_TX_WARN])
        else $error("Transmit warning flag not set.");

    a_overload_clear:
    assert property (wr_flags && wr_data[`CEF_BIT_OVERLOAD] && !overload_tx
        |=> !flags_ff[`CEF_BIT_OVERLOAD])
        else $error("Overload flag not cleared by write.");

    a_bus_off_clear:
    assert property (wr_flags && wr_data[`CEF_BIT_BUS_OFF] && transmit_error_counter < 9'h100
        |=> !flags_ff[`CEF_BIT_BUS_OFF])
        else $error("Bus-off flag not cleared by write.");

    a_passive_clear:
    assert property (wr_flags && wr_data[`CEF_BIT_PASSIVE]
        && transmit_error_counter < 9'h080 && receive_error_counter < 9'h080 |=> !flags_ff[`CEF_BIT_PASSIVE])
        else $error("Error-passive flag not cleared by write.");

    a_rx_warn_clear:
    assert property (wr_flags && wr_data[`CEF_BIT_RX_WARN] && receive_error_counter < 9'h060
        |=> !flags_ff[`CEF_BIT_RX_WARN])
        else $error("Receive warning flag not cleared by write.");

    a_tx_warn_clear:
    assert property (wr_flags && wr_data[`CEF_BIT_TX_WARN] && transmit_error_counter < 9'h060
        |=> !flags_ff[`CEF_BIT_TX_WARN])
        else $error("Transmit warning flag not cleared by write.");

    a_remote_sum_set:
    assert property (rx_done && rx_remote && !mbim_ff[rx_mbox]
        |=> flags_ff[`CEF_BIT_RFR_SUM])
        else $error("Remote summary flag not set.");

    a_remote_sum_hold:
    assert property (flags_ff[`CEF_BIT_RFR_SUM] |-> rfr_ff != 16'h0000)
        else $error("Remote summary set with empty status.");

    a_remote_sum_masked:
    assert property (rx_done && mbim_ff[rx_mbox]
        && !flags_ff[`CEF_BIT_RFR_SUM] |=> !flags_ff[`CEF_BIT_RFR_SUM])
        else $error("Remote summary set by a masked mailbox.");

    a_remote_sum_data:
    assert property (rx_done && !rx_remote
        && !flags_ff[`CEF_BIT_RFR_SUM] |=> !flags_ff[`CEF_BIT_RFR_SUM])
        else $error("Remote summary set by a data frame.");

    a_remote_sum_stay:
    assert property (flags_ff[`CEF_BIT_RFR_SUM] && !wr_rfr
        |=> flags_ff[`CEF_BIT_RFR_SUM])
        else $error("Remote summary cleared without status clear.");

    a_remote_sum_drop:
    assert property (wr_rfr && !rx_done && ((rfr_ff & ~wr_data) == 16'h0000)
        |=> !flags_ff[`CEF_BIT_RFR_SUM])
        else $error("Remote summary kept with empty status.");

    a_rx_sum_set:
    assert property (rx_done && !mbim_ff[rx_mbox]
        |=> flags_ff[`CEF_BIT_RXM_SUM])
        else $error("Receive summary flag not set.");

    a_rx_sum_hold:
    assert property (flags_ff[`CEF_BIT_RXM_SUM] |-> rxc_ff != 16'h0000)
        else $error("Receive summary set with empty status.");

    a_rx_sum_stay:
    assert property (flags_ff[`CEF_BIT_RXM_SUM] && !wr_rxc
        |=> flags_ff[`CEF_BIT_RXM_SUM])
        else $error("Receive summary cleared without status clear.");

    a_rx_sum_masked:
    assert property (rx_done && mbim_ff[rx_mbox]
        && !flags_ff[`CEF_BIT_RXM_SUM] |=> !flags_ff[`CEF_BIT_RXM_SUM])
        else $error("Receive summary set by a masked mailbox.");

    a_rx_sum_drop:
    assert property (wr_rxc && !rx_done && ((rxc_ff & ~wr_data) == 16'h0000)
        |=> !flags_ff[`CEF_BIT_RXM_SUM])
        else $error("Receive summary kept with empty status.");

    a_rx_sum_ro:
    assert property (wr_flags && flags_ff[`CEF_BIT_RXM_SUM]
        |=> flags_ff[`CEF_BIT_RXM_SUM])
        else $error("Write changed the receive summary flag.");

    a_rxc_set:
    assert property (rx_done |=> rxc_ff[$past(rx_mbox)])
        else $error("Receive complete bit not set.");

    a_remote_pair:
    assert property (rx_done && rx_remote
        |=> rfr_ff[$past(rx_mbox)] && rxc_ff[$past(rx_mbox)])
        else $error("Remote and complete bits not set together.");

    a_rxc_clear:
    assert property (wr_rxc && !rx_done
        |=> (rxc_ff & $past(wr_data)) == 16'h0000)
        else $error("Receive complete bit not cleared by write.");

    a_rxc_keep:
    assert property (!rx_done && !wr_rxc |=> rxc_ff == $past(rxc_ff))
        else $error("Receive complete bits changed without cause.");

    a_rfr_keep:
    assert property (!(rx_done && rx_remote) && !wr_rfr
        |=> rfr_ff == $past(rfr_ff))
        else $error("Remote request bits changed without cause.");

    a_zero_write_keep:
    assert property (wr_flags && wr_data[15:11] == 5'h00
        |=> (flags_ff[15:11] & $past(flags_ff[15:11]))
            == $past(flags_ff[15:11]))
        else $error("Zero write cleared a flag.");

    a_reset_zero:
    assert property (@(posedge sys_clk) disable iff (1'b0)
        rst |=> flags_ff == 16'h0000)
        else $error("Flags not zero after reset.");

    a_irq_level:
    assert property (irq == ((istat_ff & imask_ff) != 16'h0000))
        else $error("Interrupt level differs from unmasked events.");

    a_low_bits_zero:
    assert property (flags_ff[8:0] == 9'h000 && imask_ff[8:0] == 9'h000)
        else $error("Unused flag or mask bits set.");

    a_rd_idle:
    assert property (!rd_en |=> rd_data == 16'h0000)
        else $error("Read data outside a read cycle.");

    a_rd_flags:
    assert property (rd_en && addr == `CEF_ADDR_FLAGS
        |=> rd_data == $past(flags_ff))
        else $error("Flag register read back wrong.");

    a_event_overload:
    assert property (!flags_ff[`CEF_BIT_OVERLOAD]
        ##1 flags_ff[`CEF_BIT_OVERLOAD] |-> istat_ff[`CEF_BIT_OVERLOAD])
        else $error("Overload event not latched.");

    a_event_tx_warn:
    assert property (!flags_ff[`CEF_BIT_TX_WARN]
        ##1 flags_ff[`CEF_BIT_TX_WARN] |-> istat_ff[`CEF_BIT_TX_WARN])
        else $error("Transmit warning event not latched.");

    a_istat_read_clear:
    assert property (rd_istat && nxt_flags == flags_ff
        |=> istat_ff == 16'h0000)
        else $error("Event status not cleared by read.");

endmodule

/* core/cef_map.svh */
// Purpose: Offsets, field positions, thresholds and reset values.
// Assumes: Included once per file that needs it.
// Notes: Register offsets address 16-bit registers on the plain port.
`ifndef CEF_MAP_SVH
`define CEF_MAP_SVH

`define CEF_ADDR_FLAGS 8'h00
`define CEF_ADDR_RXC 8'h02
`define CEF_ADDR_RFR 8'h04
`define CEF_ADDR_MBIM 8'h06
`define CEF_ADDR_ISTAT 8'h08
`define CEF_ADDR_IMASK 8'h0A
`define CEF_ADDR_TEC 8'h0C
`define CEF_ADDR_REC 8'h0E

`define CEF_BIT_OVERLOAD 15
`define CEF_BIT_BUS_OFF 14
`define CEF_BIT_PASSIVE 13
`define CEF_BIT_RX_WARN 12
`define CEF_BIT_TX_WARN 11
`define CEF_BIT_RFR_SUM 10
`define CEF_BIT_RXM_SUM 9

`define CEF_W1C_MASK 16'hF800
`define CEF_FLAG_MASK 16'hFE00
`define CEF_WORD_RESET 16'h0000
`define CEF_MBIM_RESET 16'hFFFF

`define CEF_BUS_OFF_LIMIT 9'h100
`define CEF_PASSIVE_LIMIT 9'h080
`define CEF_WARN_LIMIT 9'h060

`endif

/* core/cef_pkg.sv */
// Purpose: Types shared by the interrupt flag block.
// Assumes: Nothing beyond standard SystemVerilog.
// Notes: Numbers live in cef_map.svh.
package cef_pkg;
    typedef logic [15:0] cef_word_t;
    typedef logic [8:0] cef_cnt_t;
    typedef logic [7:0] cef_addr_t;
    typedef logic [3:0] cef_mbox_t;
endpackage

/* test/cef_engine_model.sv */
// Purpose: Protocol engine stand-in for counters and receive events.
// Assumes: The bench commands it through its tasks.
// Notes: Mailbox lines change outside rx_done so stale values never match.
`timescale 1ns/1ps
module cef_engine_model (
    // Clock.
    input wire logic sys_clk,
    // Engine status.
    output cef_pkg::cef_cnt_t transmit_error_counter,
    output cef_pkg::cef_cnt_t receive_error_counter,
    output logic overload_tx,
    output logic rx_done,
    output logic rx_remote,
    output cef_pkg::cef_mbox_t rx_mbox
);
    import cef_pkg::*;
    initial begin
        transmit_error_counter = 9'h000;
        receive_error_counter = 9'h000;
        overload_tx = 1'b0;
        rx_done = 1'b0;
        rx_remote = 1'b1;
        rx_mbox = 4'hA;
    end
    task automatic set_cnt(input cef_cnt_t t, input cef_cnt_t r);
        @(posedge sys_clk);
        transmit_error_counter <= t;
        receive_error_counter <= r;
    endtask
    task automatic overload();
        @(posedge sys_clk);
        overload_tx <= 1'b1;
        @(posedge sys_clk);
        overload_tx <= 1'b0;
    endtask
    task automatic receive(input cef_mbox_t mb, input logic remote);
        @(posedge sys_clk);
        rx_done <= 1'b1;
        rx_remote <= remote;
        rx_mbox <= mb;
        @(posedge sys_clk);
        rx_done <= 1'b0;
        rx_remote <= ~remote;
        rx_mbox <= ~mb;
    endtask
endmodule

/* test/cef_flags_tb.sv */
// Purpose: Self-checking bench for the interrupt flag block.
// Assumes: Register port answers reads one cycle after the strobe.
// Notes: Thresholds are stepped on both sides of each limit.
`timescale 1ns/1ps
`include "cef_map.svh"
module cef_flags_tb;
    import cef_pkg::*;
    typedef struct {cef_cnt_t t; cef_cnt_t r; cef_word_t f;} cef_case_t;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    cef_addr_t addr = 8'h00;
    cef_word_t wr_data = 16'h0000;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    cef_word_t rd_data;
    cef_cnt_t transmit_error_counter;
    cef_cnt_t receive_error_counter;
    logic overload_tx;
    logic rx_done;
    logic rx_remote;
    cef_mbox_t rx_mbox;
    logic irq;
    cef_word_t v;
    int miscompares = 0;
    int total_checks = 0;
    cef_case_t cases [8] = '{'{9'h05F, 9'h05F, 16'h0000},
        '{9'h060, 9'h000, 16'h0800}, '{9'h000, 9'h060, 16'h1000},
        '{9'h07F, 9'h000, 16'h0800}, '{9'h080, 9'h000, 16'h2800},
        '{9'h000, 9'h080, 16'h3000}, '{9'h0FF, 9'h000, 16'h2800},
        '{9'h100, 9'h000, 16'h6800}};
    cef_engine_model eng (.sys_clk(sys_clk), .transmit_error_counter(transmit_error_counter), .receive_error_counter(receive_error_counter),
        .overload_tx(overload_tx), .rx_done(rx_done),
        .rx_remote(rx_remote), .rx_mbox(rx_mbox));
    cef_flags dut (.sys_clk(sys_clk), .rst(rst), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
        .rd_data(rd_data), .transmit_error_counter(transmit_error_counter), .receive_error_counter(receive_error_counter),
        .overload_tx(overload_tx), .rx_done(rx_done),
        .rx_remote(rx_remote), .rx_mbox(rx_mbox), .irq(irq));
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic wr(input cef_addr_t a, input cef_word_t d);
        @(posedge sys_clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge sys_clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input cef_addr_t a, output cef_word_t d);
        @(posedge sys_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        #1 d = rd_data;
    endtask
    task automatic check(input string n, input cef_word_t s,
        input cef_word_t e);
        total_checks++;
        if (s !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic rc(input string n, input cef_addr_t a, input cef_word_t e);
        rd(a, v);
        check(n, v, e);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        #50000;
        miscompares++;
        results();
    end
    initial begin
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        rc("flags reset", `CEF_ADDR_FLAGS, 16'h0000);
        rc("mask reset", `CEF_ADDR_MBIM, 16'hFFFF);
        foreach (cases[i]) begin
            eng.set_cnt(cases[i].t, cases[i].r);
            rc("flags", `CEF_ADDR_FLAGS, cases[i].f);
            rc("flags warn", `CEF_ADDR_FLAGS, cases[i].f);
            rc("tec", `CEF_ADDR_TEC, {7'h00, cases[i].t});
            rc("rec", `CEF_ADDR_REC, {7'h00, cases[i].r});
            eng.set_cnt(9'h000, 9'h000);
            wr(`CEF_ADDR_FLAGS, 16'hF800);
            rc("flags clr", `CEF_ADDR_FLAGS, 16'h0000);
        end
        rc("istat loop", `CEF_ADDR_ISTAT, 16'h7800);
        wr(`CEF_ADDR_IMASK, 16'hFE00);
        eng.set_cnt(9'h060, 9'h000);
        repeat (4) @(posedge sys_clk);
        #1;
        check("irq", {15'h0000, irq}, 16'h0001);
        rc("istat", `CEF_ADDR_ISTAT, 16'h0800);
        repeat (2) @(posedge sys_clk);
        #1;
        check("irq off", {15'h0000, irq}, 16'h0000);
        eng.set_cnt(9'h000, 9'h000);
        eng.overload();
        rc("ovl", `CEF_ADDR_FLAGS, 16'h8800);
        wr(`CEF_ADDR_FLAGS, 16'h0000);
        rc("ovl keep", `CEF_ADDR_FLAGS, 16'h8800);
        wr(`CEF_ADDR_FLAGS, 16'h8000);
        rc("ovl clr", `CEF_ADDR_FLAGS, 16'h0800);
        wr(`CEF_ADDR_FLAGS, 16'h0800);
        wr(`CEF_ADDR_IMASK, 16'h0000);
        eng.set_cnt(9'h100, 9'h000);
        eng.overload();
        rc("ovl off", `CEF_ADDR_FLAGS, 16'h6800);
        repeat (2) @(posedge sys_clk);
        #1;
        check("irq masked", {15'h0000, irq}, 16'h0000);
        eng.set_cnt(9'h000, 9'h000);
        wr(`CEF_ADDR_FLAGS, 16'hF800);
        eng.receive(4'h2, 1'b0);
        rc("rxc", `CEF_ADDR_RXC, 16'h0004);
        rc("sum masked", `CEF_ADDR_FLAGS, 16'h0000);
        wr(`CEF_ADDR_RXC, 16'h0000);
        rc("rxc keep", `CEF_ADDR_RXC, 16'h0004);
        wr(`CEF_ADDR_RXC, 16'h0004);
        rc("rxc clr", `CEF_ADDR_RXC, 16'h0000);
        wr(`CEF_ADDR_MBIM, 16'hFFF0);
        eng.receive(4'h3, 1'b1);
        rc("rfr", `CEF_ADDR_RFR, 16'h0008);
        rc("rxc rem", `CEF_ADDR_RXC, 16'h0008);
        rc("sums", `CEF_ADDR_FLAGS, 16'h0600);
        eng.receive(4'h1, 1'b0);
        wr(`CEF_ADDR_FLAGS, 16'h0600);
        rc("sum ro", `CEF_ADDR_FLAGS, 16'h0600);
        wr(`CEF_ADDR_RFR, 16'h0008);
        rc("rfr sum", `CEF_ADDR_FLAGS, 16'h0200);
        wr(`CEF_ADDR_RXC, 16'h0008);
        rc("rxc part", `CEF_ADDR_FLAGS, 16'h0200);
        wr(`CEF_ADDR_RXC, 16'h0002);
        rc("rxc sum", `CEF_ADDR_FLAGS, 16'h0000);
        wr(8'h20, 16'hFFFF);
        rc("unmapped", 8'h20, 16'h0000);
        eng.set_cnt(9'h060, 9'h000);
        wr(`CEF_ADDR_MBIM, 16'h0000);
        rc("flags pre", `CEF_ADDR_FLAGS, 16'h0800);
        @(posedge sys_clk);
        rst <= 1'b1;
        eng.set_cnt(9'h000, 9'h000);
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        rc("flags rst2", `CEF_ADDR_FLAGS, 16'h0000);
        rc("mask rst2", `CEF_ADDR_MBIM, 16'hFFFF);
        check("irq rst2", {15'h0000, irq}, 16'h0000);
        results();
    end
endmodule
